//--- src/adc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
    logic sclk;
    logic cs_b;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;
    // Undriven line reads as pulled high
    assign dout_line = dout_oe ? dout : 1'b1;
    modport device (input sclk, input cs_b, input din, output dout, output dout_oe);
    modport host (output sclk, output cs_b, output din, input dout_line);
endinterface : adc_link_if
`default_nettype wire

//--- src/adc_port_device.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adc_port_device
    import adc_port_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Serial link
    adc_link_if.device       link,
    // Converter core
    input  wire logic        mod_busy_i,
    input  wire logic        conv_done_i,
    input  wire logic [31:0] mod_word_i,
    input  wire logic        over_range_i,
    input  wire logic        under_range_i,
    input  wire logic        cal_done_i,
    input  wire logic        cal_overflow_i,
    input  wire logic [23:0] cal_offset_i,
    input  wire logic [23:0] cal_gain_i,
    output logic             conv_start_o,
    output logic [2:0]       conv_rate_o,
    output logic             cal_start_o,
    output logic [1:0]       cal_kind_o,
    output logic             powerdown_o,
    output logic [7:0]       control_reg_one_o,
    output logic [7:0]       control_reg_three_o,
    // GPIO pins
    input  wire logic [3:0]  gpio_pin_i,
    output logic [3:0]       gpio_dir_o,
    output logic [3:0]       gpio_level_o
);
    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_RD  = 3'b010,
        ST_WR  = 3'b100
    } link_state_e;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [2:0] sclk_s_r;
    logic [1:0] cs_s_r;
    logic [1:0] din_s_r;
    logic [3:0] gpio_s1_r;
    logic [3:0] gpio_s2_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_s_r  <= 3'h0;
            cs_s_r    <= 2'h3;
            din_s_r   <= 2'h0;
            gpio_s1_r <= 4'h0;
            gpio_s2_r <= 4'h0;
        end else begin
            sclk_s_r  <= {sclk_s_r[1:0], link.sclk};
            cs_s_r    <= {cs_s_r[0], link.cs_b};
            din_s_r   <= {din_s_r[0], link.din};
            gpio_s1_r <= gpio_pin_i;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    logic sel;
    logic rise;
    logic fall;
    logic din_b;
    assign sel   = !cs_s_r[1];
    assign rise  = sel && sclk_s_r[1] && !sclk_s_r[2];
    assign fall  = sel && !sclk_s_r[1] && sclk_s_r[2];
    assign din_b = din_s_r[1];

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    link_state_e st_r;
    logic [4:0]  cnt_r;
    logic [23:0] sh_in_r;
    logic [23:0] sh_out_r;
    logic [3:0]  sel_r;
    logic [7:0]  gpio_r;
    logic [23:0] result_r;
    logic [23:0] coef_r [4];
    logic        calib_gain_overflow_r;
    logic        over_r;
    logic        under_r;
    logic        busy_r;
    logic        rdy_r;

    logic [7:0]  cmd_byte;
    logic        cmd_fire;
    logic        rd_start;
    logic        wr_fire;
    logic [23:0] wr_val;
    logic [4:0]  last_bit;
    logic [23:0] rd_val;
    logic [4:0]  cmd_width;
    logic [1:0]  cal_bits;

    assign cmd_byte = {sh_in_r[6:0], din_b};
    assign cmd_fire = rise && (st_r == ST_CMD) && (cnt_r == 5'd7);
    assign rd_start = cmd_fire && cmd_byte[CMD_MODE_BIT] && cmd_byte[CMD_READ_BIT];
    assign wr_fire  = rise && (st_r == ST_WR) && (cnt_r == last_bit);
    assign wr_val   = {sh_in_r[22:0], din_b};
    assign cal_bits = cmd_byte[CMD_CAL_HI:CMD_CAL_LO];

    function automatic logic [4:0] width_of(input logic [3:0] s);
        return (s >= REG_RESULT && s <= REG_SELF_GAIN) ? 5'(WIDE_BITS) : 5'(NARROW_BITS);
    endfunction : width_of

    assign cmd_width = width_of(cmd_byte[CMD_SEL_MSB:CMD_SEL_LSB]);
    assign last_bit  = width_of(sel_r) - 5'd1;

    always_comb begin
        rd_val = 24'h000000;
        unique case (cmd_byte[CMD_SEL_MSB:CMD_SEL_LSB])
            REG_STATUS:      rd_val[7:0] = {calib_gain_overflow_r, conv_rate_o, over_r, under_r, busy_r, rdy_r};
            REG_CONTROL_REG_ONE:       rd_val[7:0] = control_reg_one_o;
            // Input pins show their live level
            REG_GPIO:        rd_val[7:0] = {gpio_r[7:4], (gpio_r[7:4] & gpio_r[3:0])
                                            | (~gpio_r[7:4] & gpio_s2_r)};
            REG_CONTROL_REG_THREE:       rd_val[7:0] = control_reg_three_o;
            REG_RESULT:      rd_val = result_r;
            REG_SYS_OFFSET:  rd_val = coef_r[0];
            REG_SYS_GAIN:    rd_val = coef_r[1];
            REG_SELF_OFFSET: rd_val = coef_r[2];
            REG_SELF_GAIN:   rd_val = coef_r[3];
            default:         rd_val = 24'h000000;
        endcase
    end

    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r     <= ST_CMD;
            cnt_r    <= 5'd0;
            sh_in_r  <= 24'h000000;
            sh_out_r <= 24'h000000;
            sel_r    <= 4'h0;
        end else if (!sel) begin
            st_r  <= ST_CMD;
            cnt_r <= 5'd0;
        end else if (rise) begin
            sh_in_r <= {sh_in_r[22:0], din_b};
            cnt_r   <= cnt_r + 5'd1;
            unique case (st_r)
                ST_CMD: begin
                    if (cnt_r == 5'd0 && !din_b) begin
                        cnt_r <= 5'd0;
                    end else if (cnt_r == 5'd7) begin
                        cnt_r <= 5'd0;
                        sel_r <= cmd_byte[CMD_SEL_MSB:CMD_SEL_LSB];
                        if (cmd_byte[CMD_MODE_BIT] && !cmd_byte[CMD_CAL_HI]) begin
                            st_r <= cmd_byte[CMD_READ_BIT] ? ST_RD : ST_WR;
                        end
                        sh_out_r <= rd_val << (5'(WIDE_BITS) - cmd_width);
                    end
                end
                ST_RD, ST_WR: begin
                    if (cnt_r == last_bit) begin
                        st_r  <= ST_CMD;
                        cnt_r <= 5'd0;
                    end
                end
            endcase
        end else if (fall && st_r == ST_RD) begin
            sh_out_r <= {sh_out_r[22:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link.dout    <= 1'b1;
            link.dout_oe <= 1'b0;
        end else begin
            link.dout_oe <= sel;
            if (!sel) begin
                link.dout <= 1'b1;
            end else if (st_r == ST_RD) begin
                if (fall) begin
                    link.dout <= sh_out_r[23];
                end
            end else begin
                link.dout <= !rdy_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Commands and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_start_o <= 1'b0;
            cal_start_o  <= 1'b0;
            cal_kind_o   <= CAL_NONE;
            conv_rate_o  <= 3'h0;
            powerdown_o  <= 1'b0;
            control_reg_one_o      <= CONTROL_REG_ONE_RESET;
            control_reg_three_o      <= CONTROL_REG_THREE_RESET;
            gpio_r       <= GPIO_RESET;
        end else begin
            conv_start_o <= 1'b0;
            cal_start_o  <= 1'b0;
            if (cmd_fire && !cmd_byte[CMD_MODE_BIT]) begin
                if (cal_bits != CAL_NONE) begin
                    cal_start_o <= 1'b1;
                    cal_kind_o  <= cal_bits;
                    powerdown_o <= 1'b0;
                end else if (cmd_byte[CMD_PD_BIT]) begin
                    powerdown_o <= 1'b1;
                end else begin
                    conv_start_o <= 1'b1;
                    conv_rate_o  <= cmd_byte[CMD_RATE_MSB:0];
                    powerdown_o  <= 1'b0;
                end
            end
            if (wr_fire) begin
                unique case (sel_r)
                    REG_CONTROL_REG_ONE: control_reg_one_o <= wr_val[7:0];
                    REG_GPIO:  gpio_r  <= wr_val[7:0];
                    REG_CONTROL_REG_THREE: control_reg_three_o <= wr_val[7:0];
                    default: ;
                endcase
            end
        end
    end

    assign gpio_dir_o   = gpio_r[7:4];
    assign gpio_level_o = gpio_r[3:0];

    // ------------------------------------------------------------
    // Result, status and coefficients
    // ------------------------------------------------------------
    logic [2:0]  gain_sh;
    logic [31:0] scaled;
    assign gain_sh = (control_reg_three_o[CONTROL_REG_THREE_GAIN_MSB:CONTROL_REG_THREE_GAIN_LSB] > GAIN_MAX_SHIFT)
                   ? GAIN_MAX_SHIFT : control_reg_three_o[CONTROL_REG_THREE_GAIN_MSB:CONTROL_REG_THREE_GAIN_LSB];
    assign scaled  = mod_word_i << gain_sh;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_r <= WIDE_RESET;
            over_r   <= 1'b0;
            under_r  <= 1'b0;
            busy_r   <= 1'b0;
            rdy_r    <= 1'b0;
            calib_gain_overflow_r  <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                coef_r[i] <= WIDE_RESET;
            end
        end else begin
            busy_r <= mod_busy_i;
            // Reading the result consumes it; a new one wins
            if (rd_start && cmd_byte[CMD_SEL_MSB:CMD_SEL_LSB] == REG_RESULT) begin
                rdy_r <= 1'b0;
            end
            if (conv_done_i) begin
                result_r <= {scaled[31] ^ control_reg_one_o[CONTROL_REG_ONE_FORMAT], scaled[30:8]};
                over_r   <= over_range_i;
                under_r  <= under_range_i;
                rdy_r    <= 1'b1;
            end
            if (cal_done_i) begin
                unique case (cal_kind_o)
                    CAL_SELF: begin
                        coef_r[2] <= cal_offset_i;
                        coef_r[3] <= cal_gain_i;
                    end
                    CAL_OFFSET: coef_r[0] <= cal_offset_i;
                    CAL_GAIN: begin
                        coef_r[1] <= cal_gain_i;
                        calib_gain_overflow_r   <= cal_overflow_i;
                    end
                    default: ;
                endcase
            end
            if (wr_fire && sel_r >= REG_SYS_OFFSET && sel_r <= REG_SELF_GAIN) begin
                coef_r[2'(sel_r - REG_SYS_OFFSET)] <= wr_val;
            end
        end
    end
endmodule : adc_port_device
`default_nettype wire

//--- src/adc_port_host.sv
`timescale 1ns/10ps
`default_nettype none
module adc_port_host
    import adc_port_pkg::*;
#(
    parameter int HALF_CYC = LINK_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Command port
    input  wire logic [3:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [23:0]      rdata_o,
    // Serial link
    adc_link_if.host         link
);
    // Synchroniser lag needs at least six clocks per half period
    if (HALF_CYC < 6 || HALF_CYC > 255) begin : g_half_cyc_check
        $error("HALF_CYC out of range");
    end

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_SEL  = 4'b0010,
        H_LOW  = 4'b0100,
        H_HIGH = 4'b1000
    } host_state_e;

    // ------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------
    host_state_e st_r;
    logic [7:0]  tmr_r;
    logic [5:0]  left_r;
    logic [31:0] tx_r;
    logic [23:0] rx_r;
    logic [23:0] wdata_r;
    logic [4:0]  nbits_r;
    logic [1:0]  dout_s_r;
    logic        tmr_done;
    logic        go;
    logic [4:0]  nbits;

    assign tmr_done = (tmr_r == 8'(HALF_CYC - 1));
    assign go       = wr_i && addr_i == HOST_CMD && st_r == H_IDLE;
    assign nbits    = !wdata_i[CMD_MODE_BIT] ? 5'd0
                    : (wdata_i[CMD_SEL_MSB:CMD_SEL_LSB] >= REG_RESULT
                       && wdata_i[CMD_SEL_MSB:CMD_SEL_LSB] <= REG_SELF_GAIN)
                    ? 5'(WIDE_BITS) : 5'(NARROW_BITS);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_s_r <= 2'h3;
        end else begin
            dout_s_r <= {dout_s_r[0], link.dout_line};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r      <= H_IDLE;
            tmr_r     <= 8'h00;
            left_r    <= 6'd0;
            tx_r      <= 32'h00000000;
            rx_r      <= 24'h000000;
            nbits_r   <= 5'd0;
            link.sclk <= 1'b0;
            link.cs_b <= 1'b1;
            link.din  <= 1'b0;
        end else begin
            tmr_r <= tmr_done ? 8'h00 : tmr_r + 8'h01;
            unique case (st_r)
                H_IDLE: begin
                    tmr_r <= 8'h00;
                    if (go) begin
                        // one frame for command and data
                        tx_r      <= {wdata_i[7:0] | 8'h80,
                                      wdata_r << (5'(WIDE_BITS) - nbits)};
                        left_r    <= 6'd8 + 6'(nbits);
                        nbits_r   <= nbits;
                        link.cs_b <= 1'b0;
                        st_r      <= H_SEL;
                    end
                end
                H_SEL, H_HIGH: begin
                    if (tmr_done) begin
                        if (st_r == H_HIGH) begin
                            left_r <= left_r - 6'd1;
                        end
                        if (st_r == H_HIGH && left_r == 6'd1) begin
                            link.sclk <= 1'b0;
                            link.cs_b <= 1'b1;
                            st_r      <= H_IDLE;
                        end else begin
                            link.sclk <= 1'b0;
                            link.din  <= tx_r[31];
                            tx_r      <= {tx_r[30:0], 1'b0};
                            st_r      <= H_LOW;
                        end
                    end
                end
                H_LOW: begin
                    if (tmr_done) begin
                        // capture at rising edge
                        // Device drops its last bit right after the last rise
                        rx_r      <= {rx_r[22:0], dout_s_r[1]};
                        link.sclk <= 1'b1;
                        st_r      <= H_HIGH;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command port registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdata_r <= 24'h000000;
            rdata_o <= 24'h000000;
        end else begin
            if (wr_i && addr_i == HOST_WDATA) begin
                wdata_r <= wdata_i;
            end
            rdata_o <= 24'h000000;
            if (rd_i) begin
                unique case (addr_i)
                    HOST_WDATA:  rdata_o <= wdata_r;
                    HOST_RDATA:  rdata_o <= (nbits_r == 5'(NARROW_BITS))
                                            ? {16'h0000, rx_r[7:0]} : rx_r;
                    HOST_STATUS: rdata_o <= {22'h000000, st_r != H_IDLE, dout_s_r[1]};
                    default:     rdata_o <= 24'h000000;
                endcase
            end
        end
    end
endmodule : adc_port_host
`default_nettype wire

//--- src/adc_port_pkg.sv
package adc_port_pkg;
    // ------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------
    localparam int CMD_START_BIT = 7;
    localparam int CMD_MODE_BIT  = 6;
    localparam int CMD_CAL_HI    = 5;
    localparam int CMD_CAL_LO    = 4;
    localparam int CMD_PD_BIT    = 3;
    localparam int CMD_RATE_MSB  = 2;
    localparam int CMD_SEL_MSB   = 4;
    localparam int CMD_SEL_LSB   = 1;
    localparam int CMD_READ_BIT  = 0;
    localparam logic [1:0] CAL_NONE   = 2'h0;
    localparam logic [1:0] CAL_SELF   = 2'h1;
    localparam logic [1:0] CAL_OFFSET = 2'h2;
    localparam logic [1:0] CAL_GAIN   = 2'h3;
    // ------------------------------------------------------------
    // Register selector codes and widths
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS      = 4'h0;
    localparam logic [3:0] REG_CONTROL_REG_ONE       = 4'h1;
    localparam logic [3:0] REG_GPIO        = 4'h2;
    localparam logic [3:0] REG_CONTROL_REG_THREE       = 4'h3;
    localparam logic [3:0] REG_RESULT      = 4'h4;
    localparam logic [3:0] REG_SYS_OFFSET  = 4'h5;
    localparam logic [3:0] REG_SYS_GAIN    = 4'h6;
    localparam logic [3:0] REG_SELF_OFFSET = 4'h7;
    localparam logic [3:0] REG_SELF_GAIN   = 4'h8;
    localparam int         WIDE_BITS       = 24;
    localparam int         NARROW_BITS     = 8;
    // ------------------------------------------------------------
    // Reset values and control fields
    // ------------------------------------------------------------
    localparam logic [7:0]  CONTROL_REG_ONE_RESET     = 8'h02;
    localparam logic [7:0]  GPIO_RESET      = 8'h0f;
    localparam logic [7:0]  CONTROL_REG_THREE_RESET     = 8'h1e;
    localparam logic [23:0] WIDE_RESET      = 24'h000000;
    localparam int          CONTROL_REG_ONE_FORMAT    = 2;
    localparam int          CONTROL_REG_THREE_GAIN_MSB  = 7;
    localparam int          CONTROL_REG_THREE_GAIN_LSB  = 5;
    localparam logic [2:0]  GAIN_MAX_SHIFT  = 3'h4;
    // ------------------------------------------------------------
    // Host command port and link timing
    // ------------------------------------------------------------
    localparam logic [3:0] HOST_CMD    = 4'h0;
    localparam logic [3:0] HOST_WDATA  = 4'h1;
    localparam logic [3:0] HOST_RDATA  = 4'h2;
    localparam logic [3:0] HOST_STATUS = 4'h3;
    localparam int CLK_NS       = 20;
    localparam int LINK_HALF_NS = 160;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage : adc_port_pkg

//--- tb/adc_serial_command_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_port_bench;
    import adc_port_pkg::*;
    // ----------------------------------------
    // Stimulus, instances and checking
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_q = 1'b0;
    logic        cd = 1'b0;
    logic        bsy = 1'b0;
    logic [1:0]  orng = 2'h0;
    logic [3:0]  addr_i = 4'h0;
    logic [23:0] wdata_i = 24'h0;
    logic [31:0] mw = 32'h0;
    logic [31:0] seed = 32'hd6dc;
    logic [31:0] r;
    logic [23:0] rdata_o;
    logic [2:0]  rate;
    logic [1:0]  kind;
    logic        pd;
    logic [3:0]  dir;
    logic [3:0]  lvl;
    logic [23:0] expq[$];
    logic        cal_d = 1'b0;
    logic [23:0] cgain = 24'h0;
    logic [3:0]  pins = 4'h0;
    logic        cst;
    logic        kst;
    logic [7:0]  c1;
    logic [7:0]  c3;
    int          n_conv = 0;
    int          n_cal = 0;
    int          n_mismatch = 0;
    int          checked = 0;
    int          i;
    always #10 clk_i = ~clk_i;
    adc_link_if link();
    adc_port_host u_adc_port_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
    adc_port_device u_adc_port_device (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
        .mod_busy_i(bsy), .conv_done_i(cd), .mod_word_i(mw), .over_range_i(orng[1]),
        .under_range_i(orng[0]), .cal_done_i(cal_d), .cal_overflow_i(cal_d),
        .cal_offset_i(cgain), .cal_gain_i(cgain), .conv_start_o(cst), .conv_rate_o(rate),
        .cal_start_o(kst), .cal_kind_o(kind), .powerdown_o(pd), .control_reg_one_o(c1), .control_reg_three_o(c3),
        .gpio_pin_i(pins), .gpio_dir_o(dir), .gpio_level_o(lvl));
    adc_serial_command_port_props u_adc_serial_command_port_props (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .sclk_i(link.sclk), .cs_b_i(link.cs_b), .din_i(link.din),
        .dout_i(link.dout), .dout_oe_i(link.dout_oe));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask : bus
    // Frame time is bounded, so a stuck select is a hang
    task automatic go(input logic [7:0] c, input logic [23:0] d);
        int k;
        bus(1'b1, HOST_WDATA, d);
        bus(1'b1, HOST_CMD, {16'h0, c});
        for (k = 0; k < 5 || !link.cs_b; k++) begin
            if (k > 4000) begin
                n_mismatch++;
                stop_test();
            end
            @(posedge clk_i);
        end
    endtask : go
    task automatic rreg(input logic [3:0] s, input logic [23:0] e);
        go({3'h6, s, 1'b1}, 24'h0);
        expq.push_back(e);
        bus(1'b0, HOST_RDATA, 24'h0);
    endtask : rreg
    always @(posedge clk_i) begin
        rd_q <= rd_i;
        if (cst)
            n_conv++;
        if (kst)
            n_cal++;
        if (rd_q)
            chk(rdata_o, expq.pop_front());
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rreg(REG_CONTROL_REG_ONE, 24'h02);
        rreg(REG_CONTROL_REG_THREE, 24'h1e);
        rreg(4'h9, 24'h0);
        go({3'h6, REG_GPIO, 1'b0}, 24'hf4);
        chk({16'h0, dir, lvl}, 24'hf4);
        rreg(REG_GPIO, 24'hf4);
        pins <= 4'ha;
        go({3'h6, REG_GPIO, 1'b0}, 24'h35);
        rreg(REG_GPIO, 24'h39);
        for (i = 5; i < 9; i++) begin
            r = rnd();
            go({3'h6, i[3:0], 1'b0}, r[23:0]);
            rreg(i[3:0], r[23:0]);
        end
        go(8'h88, 24'h0);
        chk({23'h0, pd}, 24'h1);
        for (i = 1; i < 4; i++) begin
            go({2'h2, i[1:0], 4'h0}, 24'h0);
            chk({22'h0, kind}, i[23:0]);
        end
        chk(n_cal[23:0], 24'h3);
        r = rnd();
        cgain <= r[23:0];
        cal_d <= 1'b1;
        @(posedge clk_i);
        cal_d <= 1'b0;
        rreg(REG_SYS_GAIN, r[23:0]);
        for (i = 0; i < 8; i++) begin
            go({5'h10, i[2:0]}, 24'h0);
            chk({21'h0, rate}, i[23:0]);
        end
        chk(n_conv[23:0], 24'h8);
        go({3'h6, REG_CONTROL_REG_ONE, 1'b0}, 24'h06);
        chk({16'h0, c1}, 24'h06);
        go({3'h6, REG_CONTROL_REG_THREE, 1'b0}, 24'h3e);
        chk({16'h0, c3}, 24'h3e);
        @(posedge clk_i);
        mw <= rnd();
        orng <= 2'h2;
        bsy <= 1'b1;
        cd <= 1'b1;
        @(posedge clk_i);
        cd <= 1'b0;
        rreg(REG_STATUS, 24'hfb);
        rreg(REG_RESULT, {~mw[30], mw[29:7]});
        rreg(REG_STATUS, 24'hfa);
        // Last read is compared two edges after its strobe
        repeat (3) @(posedge clk_i);
        if (expq.size() != 0) begin
            n_mismatch++;
        end
        stop_test();
    end
endmodule : adc_serial_command_port_bench
`default_nettype wire

//--- tb/adc_serial_command_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module adc_serial_command_port_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link lines
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic din_i,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    // ----------------------------------------
    // Rises seen in the current frame
    // ----------------------------------------
    logic [5:0] rises_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            rises_r <= 6'h0;
        else if (cs_b_i)
            rises_r <= 6'h0;
        else if ($rose(sclk_i))
            rises_r <= rises_r + 6'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_high_phase;
        sclk_i [*8] ##1 !sclk_i;
    endsequence
    a_idle_no_drive: assert property (cs_b_i [*4] |-> !dout_oe_i)
        else $error("dout driven while deselected");
    a_clock_parked: assert property (cs_b_i [*3] |-> !sclk_i)
        else $error("serial clock moves outside a frame");
    a_half_period: assert property ($rose(sclk_i) |-> s_high_phase)
        else $error("serial clock high phase wrong length");
    a_din_held: assert property ($rose(sclk_i) |-> $stable(din_i))
        else $error("din changed at a rising edge");
    a_dout_settled: assert property ($rose(sclk_i) && dout_oe_i |=> $stable(dout_i))
        else $error("dout moved right after a rising edge");
    a_start_bit: assert property ($rose(sclk_i) && rises_r == 6'h0 |-> din_i)
        else $error("first command bit is not one");
    a_whole_frame: assert property ($rose(cs_b_i) |->
        rises_r == 6'h08 || rises_r == 6'h10 || rises_r == 6'h20)
        else $error("frame ended mid word");
    a_select_drives: assert property ($fell(cs_b_i) |-> ##[1:5] dout_oe_i)
        else $error("line not driven after select");
endmodule : adc_serial_command_port_props
`default_nettype wire
